/* File: dv/rsw_top_test.sv */
// Purpose: self-checking bench for the reset sequencer with watchdog
// Assumes: short watchdog periods through P_SHIFT_BASE = 2
// Notes:   watchdog ticks come every 4 cycles from one shared divider
`timescale 1ns/1ps
`default_nettype none
module rsw_top_test;
    import rsw_pkg::*;
    localparam int TB_SHIFT = 2;  // rate 1 period is 4 ticks
    logic        i_clk, i_rst;                // clock, reset
    logic        cyc, stb, we, ack;           // bus master side
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, rd;
    logic        pin_ext, pin_oe_n, pin_lvl;  // pulled-up reset wire
    logic        pin_drv;                     // value the device drives
    logic        por, illegal, low_voltage_reset, osc_fail; // reset sources
    logic        nmode, stop, nvm_ok;         // mode and preload
    logic [2:0]  nvm_rate;
    logic        sys_rst, osc_en;             // system outputs
    logic [1:0]  vec;
    logic        rc_on, ac_on, rc_tk, ac_tk;  // tick sources
    logic        os_on, os_tk, osc_q;         // oscillator ticks, qualified
    logic [1:0]  tdiv;
    int          ntk, n_fail, checked;
    // wire level: the device pulls low, otherwise the far side decides
    assign pin_lvl = (pin_oe_n | pin_drv) & pin_ext;
    rsw_top #(
        .P_SHIFT_BASE (TB_SHIFT)
    ) i_rsw_top (
        .i_clk (i_clk), .i_rst (i_rst), .i_ce (1'b1),
        .i_wb_cyc (cyc), .i_wb_stb (stb), .i_wb_we (we),
        .i_wb_adr (adr), .i_wb_sel (4'h1), .i_wb_dat (wdat),
        .o_wb_dat (rdat), .o_wb_ack (ack),
        .i_rst_pin (pin_lvl), .o_rst_pin_o (pin_drv),
        .o_rst_pin_oe_n (pin_oe_n),
        .i_por (por), .i_low_voltage_reset (low_voltage_reset),
        .i_illegal_addr (illegal), .i_osc_fail (osc_fail),
        .i_normal_mode (nmode), .i_stop_mode (stop),
        .i_oscillator_qualified (osc_q), .i_autonomous_tick (ac_tk),
        .i_internal_rc_tick (rc_tk), .i_oscillator_tick (os_tk),
        .i_nvm_valid (nvm_ok), .i_nvm_rate (nvm_rate), .i_nvm_window (1'b0),
        .o_sys_rst (sys_rst), .o_vector (vec), .o_oscillator_enable (osc_en)
    );
    // free-running clock, 8 ns period
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // shared tick divider; ntk counts ticks the design has seen
    always @(posedge i_clk)
    begin
        tdiv  <= tdiv + 2'h1;
        rc_tk <= rc_on && tdiv == 2'h3;
        ac_tk <= ac_on && tdiv == 2'h3;
        os_tk <= os_on && tdiv == 2'h3;
        if (rc_tk || ac_tk || os_tk)
            ntk <= ntk + 1;
    end
    // one comparison, reported at once
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    // classic single cycle; request held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h0, d};
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
            n_fail++;   // no answer counts as a mismatch
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // bounded wait for the internal reset to reach a level
    task automatic wait_sys(input logic v, input int lim);
        int n;
        n = 0;
        while (sys_rst !== v && n < lim)
        begin
            @(posedge i_clk);
            n++;
        end
    endtask : wait_sys
    // wait for k more ticks; the watchdog process guards a hang
    task automatic wait_tk(input int k);
        int t0;
        t0 = ntk;
        while (ntk - t0 < k)
            @(posedge i_clk);
    endtask : wait_tk
    // drive and wait phases counted for three different sources
    task automatic t_seq();
        int nd, nw;
        for (int s = 0; s < 3; s++)
        begin
            nd = 0;
            nw = 0;
            @(posedge i_clk);
            por     <= s == 0;
            illegal <= s == 1;
            low_voltage_reset     <= s == 2;
            @(posedge i_clk);
            por     <= 1'b0;
            illegal <= 1'b0;
            low_voltage_reset     <= 1'b0;
            repeat (820)
            begin
                @(posedge i_clk);
                if (pin_oe_n === 1'b0)
                    nd++;
                else if (sys_rst === 1'b1)
                    nw++;
            end
            chk(nd, 512);
            chk(nw, 256);
            chk(vec, VEC_POR);
            wb(1'b0, OFF_STATUS, 8'h00);
            chk(rd[3:2], 2'h0);
        end
    endtask : t_seq
    // preload, masked write, write-once and select lock
    task automatic t_once();
        wb(1'b0, OFF_CTRL, 8'h00);
        chk(rd[2:0], 3'h3);
        wb(1'b1, OFF_CTRL, 8'h81);
        wb(1'b0, OFF_STATUS, 8'h00);
        chk(rd[ST_ONCE_DONE], 1'b0);
        wb(1'b1, OFF_CFG, 8'h04);
        wb(1'b0, OFF_CFG, 8'h00);
        chk(rd[7:0], 8'h04);
        wb(1'b1, OFF_CTRL, 8'h00);
        wb(1'b0, OFF_CTRL, 8'h00);
        chk(rd[2:0], 3'h3);
        wb(1'b1, OFF_CTRL, 8'h41);
        wb(1'b0, OFF_CTRL, 8'h00);
        chk(rd[7:0], 8'h03);
        wb(1'b1, OFF_CFG, 8'h00);
        wb(1'b0, OFF_CFG, 8'h00);
        chk(rd[7:0], 8'h04);
        nmode  <= 1'b0;
        nvm_ok <= 1'b0;
        wb(1'b1, OFF_SERVICE, 8'h33);
        wait_sys(1'b1, 4);
        chk(sys_rst, 1'b1);
        wait_sys(1'b0, 1000);
        chk(vec, VEC_WDOG);
    endtask : t_once
    // pin held low well past the sequence
    task automatic t_pin();
        pin_ext <= 1'b0;
        repeat (1000) @(posedge i_clk);
        chk(sys_rst, 1'b1);
        pin_ext <= 1'b1;
        wait_sys(1'b0, 20);
        chk(sys_rst, 1'b0);
        chk(vec, VEC_POR);
    endtask : t_pin
    // rates 0 to 3: off, then 4, 16 and 64 ticks to a trip
    task automatic t_rate();
        int t0, p;
        wb(1'b1, OFF_CTRL, 8'h01);
        ac_on <= 1'b1;
        repeat (100) @(posedge i_clk);
        chk(sys_rst, 1'b0);
        ac_on <= 1'b0;
        for (int r = 0; r < 4; r++)
        begin
            wb(1'b1, OFF_CTRL, 8'(r));
            t0 = ntk;
            p = 4 ** r;
            rc_on <= 1'b1;
            wait_sys(1'b1, 400);
            rc_on <= 1'b0;
            chk(sys_rst, r != 0);
            if (r != 0)
            begin
                chk(ntk - t0 >= p - 1 && ntk - t0 <= p + 1, 1'b1);
                wait_sys(1'b0, 1000);
                chk(vec, VEC_WDOG);
            end
        end
    endtask : t_rate
    // windowed service late in the period, then one too early
    task automatic t_window();
        wb(1'b1, OFF_CTRL, 8'h42);
        rc_on <= 1'b1;
        repeat (3)
        begin
            wait_tk(12);
            wb(1'b1, OFF_SERVICE, KEY_FIRST);
            wb(1'b1, OFF_SERVICE, KEY_SECOND);
        end
        chk(sys_rst, 1'b0);
        wb(1'b1, OFF_SERVICE, KEY_FIRST);
        wait_sys(1'b1, 4);
        chk(sys_rst, 1'b1);
        rc_on <= 1'b0;
        wait_sys(1'b0, 1000);
        chk(vec, VEC_WDOG);
    endtask : t_window
    // failing oscillator: ignored in full stop, reset outside it
    task automatic t_clkmon();
        wb(1'b1, OFF_CFG, 8'h08);
        stop     <= 1'b1;
        osc_fail <= 1'b1;
        repeat (20) @(posedge i_clk);
        chk(osc_en, 1'b0);
        chk(sys_rst, 1'b0);
        stop <= 1'b0;
        wait_sys(1'b1, 10);
        chk(sys_rst, 1'b1);
        osc_fail <= 1'b0;
        wait_sys(1'b0, 1000);
        chk(vec, VEC_CLKMON);
        wb(1'b0, OFF_STATUS, 8'h00);
        chk(rd[3:2], 2'h0);
    endtask : t_clkmon
    // stop mode: frozen autonomous, frozen rc, running autonomous,
    // running oscillator in pseudo stop
    task automatic t_stop();
        logic [7:0] cfg [4] = '{8'h06, 8'h00, 8'h02, 8'h39};
        for (int c = 0; c < 4; c++)
        begin
            wb(1'b1, OFF_CFG, cfg[c]);
            wb(1'b1, OFF_CTRL, 8'h01);
            // next stop only after a full sequence
            stop <= 1'b1;
            repeat (20) @(posedge i_clk);
            ac_on <= c == 0 || c == 2;
            rc_on <= c == 1;
            os_on <= c == 3;
            osc_q <= c == 3;
            repeat (100) @(posedge i_clk);
            chk(sys_rst, c >= 2);
            stop <= 1'b0;
            wait_sys(1'b1, 60);
            chk(sys_rst, 1'b1);
            ac_on <= 1'b0;
            rc_on <= 1'b0;
            os_on <= 1'b0;
            wait_sys(1'b0, 1000);
        end
    endtask : t_stop
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    // hang guard, well beyond the expected run length
    initial
    begin
        #(8 * 40000);
        n_fail++;
        stop_test();
    end
    // main sequence
    initial
    begin
        {cyc, stb, we, por, illegal, low_voltage_reset, osc_fail, stop, osc_q} = '0;
        {rc_on, ac_on, os_on, rc_tk, ac_tk, os_tk, tdiv} = '0;
        {ntk, n_fail, checked} = '0;
        adr      = 8'h00;
        wdat     = 32'h0;
        pin_ext  = 1'b1;
        nmode    = 1'b1;
        nvm_ok   = 1'b1;
        nvm_rate = 3'h3;
        i_rst    = 1'b1;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        wait_sys(1'b0, 1000);
        t_seq();
        t_once();
        t_pin();
        t_rate();
        t_window();
        t_clkmon();
        t_stop();
        stop_test();
    end
endmodule : rsw_top_test
`default_nettype wire

/* File: src/rsw_pkg.sv */
// Purpose: constants for the reset sequencer with watchdog
// Assumes: one pll_output_clock domain, watchdog clocks arrive as ticks
// Notes:   offsets are byte addresses of 32-bit words
package rsw_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_SERVICE  = 8'h04;
    localparam logic [7:0] OFF_CFG      = 8'h08;
    localparam logic [7:0] OFF_STATUS   = 8'h0C;
    // control register fields
    localparam int         CTRL_RATE_LSB = 0;
    localparam int         CTRL_WIN_BIT  = 6;
    localparam int         CTRL_MASK_BIT = 7;
    // configuration register fields
    localparam int         CFG_SEL_LOW   = 0;
    localparam int         CFG_SEL_HIGH  = 1;
    localparam int         CFG_STOP_DIS  = 2;
    localparam int         CFG_OSC_EN    = 3;
    localparam int         CFG_PSTOP     = 4;
    localparam int         CFG_PSTOP_WD  = 5;
    // status register fields
    localparam int         ST_VEC_LSB    = 0;
    localparam int         ST_WD_PEND    = 2;
    localparam int         ST_CM_PEND    = 3;
    localparam int         ST_ONCE_DONE  = 4;
    localparam int         ST_PRELOAD_ON = 5;
    localparam int         ST_SYS_RST    = 6;
    // service keys and reset values
    localparam logic [7:0] KEY_FIRST     = 8'h55;
    localparam logic [7:0] KEY_SECOND    = 8'hAA;
    localparam logic [2:0] RATE_OFF      = 3'h0;
    // reset sequence lengths in pll_output_clock cycles
    localparam int         DRIVE_CYCLES  = 512;
    localparam int         WAIT_CYCLES   = 256;
    localparam int         SEQ_CYCLES    = DRIVE_CYCLES + WAIT_CYCLES;
    localparam logic [8:0] DRIVE_LAST    = 9'(DRIVE_CYCLES - 1);
    localparam logic [8:0] WAIT_LAST     = 9'(WAIT_CYCLES - 1);
    // reset vectors
    localparam logic [1:0] VEC_POR       = 2'h0;
    localparam logic [1:0] VEC_CLKMON    = 2'h1;
    localparam logic [1:0] VEC_WDOG      = 2'h2;
    // sequencer states, one-hot
    typedef enum logic [3:0] {
        SQ_IDLE  = 4'b0001,
        SQ_DRIVE = 4'b0010,
        SQ_WAIT  = 4'b0100,
        SQ_HOLD  = 4'b1000
    } rsw_state_t;
endpackage : rsw_pkg

/* File: src/rsw_top.sv */
// Purpose: reset sequencer, clock monitor reset and watchdog
// Assumes: all inputs synchronous to i_clk, watchdog clocks as ticks
// Notes:   classic Wishbone slave, one-cycle registered ack
`timescale 1ns/1ps
`default_nettype none
module rsw_top
    import rsw_pkg::*;
#(
    parameter int P_SHIFT_BASE = 14  // rate 1 period is 2**this ticks
)(
    // clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    // reset pin, open drain
    input  wire logic        i_rst_pin,
    output logic             o_rst_pin_o,
    output logic             o_rst_pin_oe_n,
    // reset sources
    input  wire logic        i_por,
    input  wire logic        i_low_voltage_reset,
    input  wire logic        i_illegal_addr,
    input  wire logic        i_osc_fail,
    // mode and clock status
    input  wire logic        i_normal_mode,
    input  wire logic        i_stop_mode,
    input  wire logic        i_oscillator_qualified,
    input  wire logic        i_autonomous_tick,
    input  wire logic        i_internal_rc_tick,
    input  wire logic        i_oscillator_tick,
    // nonvolatile preload
    input  wire logic        i_nvm_valid,
    input  wire logic [2:0]  i_nvm_rate,
    input  wire logic        i_nvm_window,
    // system outputs
    output logic             o_sys_rst,
    output logic [1:0]       o_vector,
    output logic             o_oscillator_enable
);
    // sequencer
    rsw_state_t  st_r;            // sequencer state
    logic [8:0]  cnt_r;           // cycle count in state
    logic [1:0]  vec_r;           // chosen vector
    logic        seq_done;        // sequence ends this cycle
    logic        any_src;         // some reset source active
    // pending flags
    logic        wd_pend_r;
    logic        cm_pend_r;
    // control and config
    logic [2:0]  timeout_rate_r;
    logic        window_mode_enable_r;
    logic        once_done_r;     // write-once used up
    logic        preload_on_r;    // preload had enabled watchdog
    logic        sel_low_r;
    logic        sel_high_r;
    logic        stop_dis_r;
    logic        oscillator_enable_r;
    logic        pseudo_stop_select_r;
    logic        pstop_wd_en_r;
    // watchdog
    logic [31:0] wd_cnt_r;        // elapsed ticks
    logic [31:0] wd_lim;          // last tick of period
    logic [4:0]  wd_shift;
    logic        wd_on;
    logic        wd_tick;
    logic        win_open;
    logic        armed_r;         // first key seen
    logic        svc_bad;
    logic        svc_restart;
    logic        wd_timeout;
    logic        wd_trip_r;       // one-cycle watchdog reset event
    logic        stop_s1_r;       // stop seen by autonomous domain
    logic        stop_s2_r;
    logic        osc_stop_run;
    logic        full_stop;
    logic        cm_evt;
    // bus
    logic        acc;             // new access this cycle
    logic        wr;
    logic        ack_r;
    logic [31:0] rdat_r;
    logic [7:0]  wbyte;

    assign acc   = i_wb_cyc & i_wb_stb & ~ack_r;
    assign wr    = acc & i_wb_we & i_wb_sel[0];
    assign wbyte = i_wb_dat[7:0];

    // full stop gates oscillator and monitor
    assign full_stop           = i_stop_mode & ~pseudo_stop_select_r;
    assign o_oscillator_enable = oscillator_enable_r & ~full_stop;
    assign cm_evt = o_oscillator_enable & i_osc_fail;

    // any source starts a sequence from idle
    assign any_src = i_por | i_low_voltage_reset | i_illegal_addr
                   | ~i_rst_pin | cm_evt | wd_trip_r;
    assign seq_done = ((st_r == SQ_WAIT) && (cnt_r == WAIT_LAST)
                       && i_rst_pin) || ((st_r == SQ_HOLD) && i_rst_pin);

    // reset sequencer state machine
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_r  <= SQ_DRIVE;    // power-up runs a full sequence
            cnt_r <= 9'h000;
        end
        else if (i_ce)
        begin
            case (st_r)
                SQ_IDLE:
                begin
                    cnt_r <= 9'h000;
                    if (any_src)
                        st_r <= SQ_DRIVE;
                end
                // pin held low for fixed count
                SQ_DRIVE:
                begin
                    cnt_r <= cnt_r + 9'h001;
                    if (cnt_r == DRIVE_LAST)
                    begin
                        st_r  <= SQ_WAIT;
                        cnt_r <= 9'h000;
                    end
                end
                SQ_WAIT:
                begin
                    cnt_r <= cnt_r + 9'h001;
                    if (cnt_r == WAIT_LAST)
                        st_r <= i_rst_pin ? SQ_IDLE : SQ_HOLD;
                end
                SQ_HOLD:
                begin
                    if (i_rst_pin)
                        st_r <= SQ_IDLE;
                end
                default:
                    st_r <= SQ_DRIVE;
            endcase
        end
    end

    // vector picked at the sample point
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            vec_r <= VEC_POR;
        else if (i_ce && (st_r == SQ_WAIT) && (cnt_r == WAIT_LAST))
        begin
            if (!i_rst_pin)
                vec_r <= VEC_POR;     // pin low means external origin
            else if (cm_pend_r)
                vec_r <= VEC_CLKMON;
            else if (wd_pend_r)
                vec_r <= VEC_WDOG;
            else
                vec_r <= VEC_POR;
        end
    end

    // pending flags, set wins over clear
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wd_pend_r <= 1'b0;
            cm_pend_r <= 1'b0;
        end
        else if (i_ce)
        begin
            wd_pend_r <= wd_trip_r | (wd_pend_r & ~seq_done);
            cm_pend_r <= cm_evt | (cm_pend_r & ~seq_done);
        end
    end

    assign o_sys_rst      = (st_r != SQ_IDLE);
    assign o_vector       = vec_r;
    assign o_rst_pin_o    = 1'b0;
    // drive only during the drive phase
    assign o_rst_pin_oe_n = (st_r != SQ_DRIVE);

    // control, config and write-once; cleared during a sequence, preloaded at its end in normal mode with valid nvm
    always_ff @(posedge i_clk)
    begin
        if (i_rst || o_sys_rst)
        begin
            timeout_rate_r       <= RATE_OFF;
            window_mode_enable_r <= 1'b0;
            once_done_r          <= 1'b0;
            preload_on_r         <= 1'b0;
            sel_low_r            <= 1'b0;   // rc clock default
            sel_high_r           <= 1'b0;
            stop_dis_r           <= 1'b0;
            oscillator_enable_r  <= 1'b0;
            pseudo_stop_select_r <= 1'b0;
            pstop_wd_en_r        <= 1'b0;
            if (!i_rst && i_ce && seq_done && i_normal_mode
                && i_nvm_valid)
            begin
                timeout_rate_r       <= i_nvm_rate;
                window_mode_enable_r <= i_nvm_window;
                preload_on_r         <= (i_nvm_rate != RATE_OFF);
            end
        end
        else if (i_ce)
        begin
            // one unmasked write in normal mode
            if (wr && (i_wb_adr == OFF_CTRL) && !wbyte[CTRL_MASK_BIT]
                && (!once_done_r || !i_normal_mode))
            begin
                once_done_r          <= i_normal_mode;
                window_mode_enable_r <= wbyte[CTRL_WIN_BIT];
                // off refused once preload enabled the watchdog
                if (!(preload_on_r &&
                      wbyte[CTRL_RATE_LSB +: 3] == RATE_OFF))
                    timeout_rate_r <= wbyte[CTRL_RATE_LSB +: 3];
            end
            if (wr && (i_wb_adr == OFF_CFG))
            begin
                oscillator_enable_r  <= wbyte[CFG_OSC_EN];
                pseudo_stop_select_r <= wbyte[CFG_PSTOP];
                pstop_wd_en_r        <= wbyte[CFG_PSTOP_WD];
                if (!once_done_r)
                begin
                    sel_low_r  <= wbyte[CFG_SEL_LOW];
                    sel_high_r <= wbyte[CFG_SEL_HIGH];
                    stop_dis_r <= wbyte[CFG_STOP_DIS];
                end
            end
        end
    end

    // stop seen through two autonomous ticks each way
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            stop_s1_r <= 1'b0;
            stop_s2_r <= 1'b0;
        end
        else if (i_ce && i_autonomous_tick)
        begin
            stop_s1_r <= i_stop_mode;
            stop_s2_r <= stop_s1_r;
        end
    end

    // oscillator keeps running in pseudo stop only
    assign osc_stop_run = pseudo_stop_select_r & pstop_wd_en_r & sel_low_r
                        & oscillator_enable_r & i_oscillator_qualified;

    always_comb
    begin
        if (sel_high_r)
            wd_tick = i_autonomous_tick & ~(stop_dis_r & stop_s2_r);
        else if (sel_low_r)
            wd_tick = i_oscillator_tick & (~i_stop_mode | osc_stop_run);
        else
            wd_tick = i_internal_rc_tick & ~i_stop_mode;
    end

    // rate selects period, zero is off
    assign wd_on    = (timeout_rate_r != RATE_OFF);
    assign wd_shift = 5'(P_SHIFT_BASE) + {timeout_rate_r - 3'h1, 1'b0};
    assign wd_lim   = (32'h1 << wd_shift) - 32'h1;
    assign win_open = (wd_cnt_r >= (wd_lim - (wd_lim >> 2)));
    assign wd_timeout = wd_on & wd_tick & (wd_cnt_r == wd_lim);

    assign svc_bad = wd_on & wr & (i_wb_adr == OFF_SERVICE)
                   & (((wbyte != KEY_FIRST) && (wbyte != KEY_SECOND))
                      | (window_mode_enable_r & ~win_open));
    // ordered key pair restarts the period
    assign svc_restart = wd_on & wr & (i_wb_adr == OFF_SERVICE) & ~svc_bad
                       & (wbyte == KEY_SECOND) & armed_r;

    // watchdog counter and key tracking
    always_ff @(posedge i_clk)
    begin
        if (i_rst || o_sys_rst)
        begin
            wd_cnt_r  <= 32'h0;
            armed_r   <= 1'b0;
            wd_trip_r <= 1'b0;
        end
        else if (i_ce)
        begin
            wd_trip_r <= svc_bad | wd_timeout;
            if (!wd_on || svc_restart || wd_timeout)
                wd_cnt_r <= 32'h0;
            else if (wd_tick)
                wd_cnt_r <= wd_cnt_r + 32'h1;
            // a lone second key breaks the pair
            if (wd_on && wr && (i_wb_adr == OFF_SERVICE) && !svc_bad)
                armed_r <= (wbyte == KEY_FIRST);
        end
    end

    // wishbone ack and read data, unmapped reads zero
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0;
        end
        else if (i_ce)
        begin
            ack_r  <= acc;
            rdat_r <= 32'h0;
            if (acc && !i_wb_we)
            begin
                case (i_wb_adr)
                    OFF_CTRL:
                    begin
                        rdat_r[CTRL_RATE_LSB +: 3] <= timeout_rate_r;
                        rdat_r[CTRL_WIN_BIT]       <= window_mode_enable_r;
                    end
                    OFF_CFG:
                    begin
                        rdat_r[CFG_SEL_LOW]  <= sel_low_r;
                        rdat_r[CFG_SEL_HIGH] <= sel_high_r;
                        rdat_r[CFG_STOP_DIS] <= stop_dis_r;
                        rdat_r[CFG_OSC_EN]   <= oscillator_enable_r;
                        rdat_r[CFG_PSTOP]    <= pseudo_stop_select_r;
                        rdat_r[CFG_PSTOP_WD] <= pstop_wd_en_r;
                    end
                    OFF_STATUS:
                    begin
                        rdat_r[ST_VEC_LSB +: 2] <= vec_r;
                        rdat_r[ST_WD_PEND]      <= wd_pend_r;
                        rdat_r[ST_CM_PEND]      <= cm_pend_r;
                        rdat_r[ST_ONCE_DONE]    <= once_done_r;
                        rdat_r[ST_PRELOAD_ON]   <= preload_on_r;
                        rdat_r[ST_SYS_RST]      <= o_sys_rst;
                    end
                    default:
                        rdat_r <= 32'h0;
                endcase
            end
        end
    end

    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;

    // checks, frozen cycles excluded
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst || !i_ce);

    sequence s_drive_end;
        (st_r == SQ_DRIVE) && (cnt_r == DRIVE_LAST);
    endsequence
    sequence s_sample_high;
        (st_r == SQ_WAIT) && (cnt_r == WAIT_LAST) && i_rst_pin;
    endsequence
    sequence s_ctrl_masked;
        wr && (i_wb_adr == OFF_CTRL) && wbyte[CTRL_MASK_BIT];
    endsequence

    a_drive_phase: assert property (s_drive_end |=> (st_r == SQ_WAIT)
        && o_rst_pin_oe_n && (cnt_r == 9'h000))
        else $error("drive phase did not end into wait");
    a_wait_sample: assert property (s_sample_high |=> (st_r == SQ_IDLE)
        && !o_sys_rst)
        else $error("sample point did not end sequence");
    a_vec_clkmon: assert property ((s_sample_high and cm_pend_r)
        |=> (o_vector == VEC_CLKMON))
        else $error("clock monitor vector not chosen");
    a_vec_wdog: assert property ((s_sample_high and !cm_pend_r
        and wd_pend_r) |=> (o_vector == VEC_WDOG))
        else $error("watchdog vector not chosen");
    a_hold_low: assert property (((st_r == SQ_HOLD) && !i_rst_pin)
        |=> o_sys_rst && (st_r == SQ_HOLD))
        else $error("reset released while pin low");
    a_full_stop: assert property (full_stop |-> !o_oscillator_enable
        && !cm_evt)
        else $error("clock monitor active in full stop");
    a_bad_key: assert property ((svc_bad ##1 1'b1) |-> wd_trip_r
        ##1 o_sys_rst)
        else $error("bad service write did not reset");
    a_mask_ignored: assert property (s_ctrl_masked |=>
        $stable(timeout_rate_r) && $stable(once_done_r))
        else $error("masked control write took effect");
    a_once_lock: assert property ((once_done_r && wr
        && (i_wb_adr == OFF_CFG)) |=> $stable(sel_high_r)
        && $stable(sel_low_r) && $stable(stop_dis_r))
        else $error("clock select changed after write-once");
    a_pend_kept: assert property ((wd_pend_r && !seq_done)
        |=> wd_pend_r)
        else $error("watchdog pending lost before sampling");
endmodule : rsw_top
`default_nettype wire
